// file: rtl/eopb_bank.sv
/*
 Ethernet option parameter bank: staged communication settings, apply
 mechanism, read-only mirrors and status/control address lists.
 Assumes a single 125 MHz ref_clk, synchronous active-low reset, a
 register master per the plain strobe port, and an asynchronous protocol
 switch pin and link ability pins.
*/
// Behaviour
// - Read-only module version, no operator entry
// - Four LED states mirrored, order by mode
// - Only IPv4 addressing supported
// - Twelve octet registers, each 0 to 255
// - First octet register is leftmost octet
// - Speed 0 auto, 1 100M, 2 10M
// - Auto picks highest available speed
// - Instance selectors hidden in TCP mode
// - Input selector 0..11, instance mapping
// - Output selector 0..11, instance mapping
// - Status count updates on apply, selector>=4
// - Control count updates on apply, selector>=4
// - Send values at first N status addresses
// - Write output words to first N addresses
// - Settings staged until apply written 1; status/control address lists act without apply
// - Apply restarts comms and commits to nonvolatile
// - Protocol latched at power-up or apply
`timescale 1ns/1ns
`include "eopb_cfg.svh"

module eopb_bank #(
  parameter logic [15:0] VERSION_CODE = 16'h0001 // Arbitrary value
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // Register port
  input  wire logic [5:0]           reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [15:0]               reg_rdata,
  // Pins and indicator sources
  input  wire logic                 proto_switch,
  input  wire logic                 net_can_100,
  input  wire logic                 net_can_10,
  input  wire logic [3:0]           led_state,
  // Active configuration to the protocol engine
  output logic                      proto_ind,
  output logic [31:0]               ip_addr,
  output logic [31:0]               net_mask,
  output logic [31:0]               gateway,
  output logic [7:0]                in_instance,
  output logic [7:0]                out_instance,
  output logic [3:0]                stat_cnt,
  output logic [3:0]                ctrl_cnt,
  output eopb_pkg::eopb_speed_t     link_speed,
  output logic                      comm_restart,
  output logic                      nv_commit,
  // Cyclic data exchange with the drive parameter space
  input  wire logic [2:0]           stat_idx,
  output logic [15:0]               stat_param_addr,
  output logic                      stat_idx_valid,
  input  wire logic [2:0]           ctrl_idx,
  output logic [15:0]               ctrl_param_addr,
  output logic                      ctrl_idx_valid
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [7:0] in_inst_of(input logic [3:0] sel);
    case (sel)
      4'h0: in_inst_of = 8'h46;
      4'h1: in_inst_of = 8'h47;
      4'h2: in_inst_of = 8'h6e;
      4'h3: in_inst_of = 8'h6f;
      default: in_inst_of = 8'(8'h89 + {4'h0, sel}); // 141 + sel - 4
    endcase
  endfunction : in_inst_of

  function automatic logic [7:0] out_inst_of(input logic [3:0] sel);
    case (sel)
      4'h0: out_inst_of = 8'h14;
      4'h1: out_inst_of = 8'h15;
      4'h2: out_inst_of = 8'h64;
      4'h3: out_inst_of = 8'h65;
      default: out_inst_of = 8'(8'h75 + {4'h0, sel}); // 121 + sel - 4
    endcase
  endfunction : out_inst_of

  function automatic logic [3:0] cnt_of(input logic [3:0] sel);
    cnt_of = 4'(sel - 4'h3);
  endfunction : cnt_of

  function automatic logic is_wr(input logic [5:0] a, input logic [5:0] base);
    is_wr = reg_wr && (reg_addr == base) && (a == base);
  endfunction : is_wr

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] sw_sync;
  logic [2:0] c100_sync;
  logic [2:0] c10_sync;
  logic       sw_level;
  logic       c100_level;
  logic       c10_level;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sw_sync   <= 3'h0;
      c100_sync <= 3'h0;
      c10_sync  <= 3'h0;
    end else begin
      sw_sync   <= {sw_sync[1:0], proto_switch};
      c100_sync <= {c100_sync[1:0], net_can_100};
      c10_sync  <= {c10_sync[1:0], net_can_10};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sw_level   <= 1'b0;
      c100_level <= 1'b0;
      c10_level  <= 1'b0;
    end else begin
      if (sw_sync[1] == sw_sync[2]) begin
        sw_level <= sw_sync[2];
      end
      if (c100_sync[1] == c100_sync[2]) begin
        c100_level <= c100_sync[2];
      end
      if (c10_sync[1] == c10_sync[2]) begin
        c10_level <= c10_sync[2];
      end
    end
  end

  // ----------------------------------------
  // Staged settings
  // ----------------------------------------
  logic [7:0]  octet      [`EOPB_OCTET_CNT];
  logic [1:0]  speed_stage;
  logic [3:0]  in_sel;
  logic [3:0]  out_sel;
  logic [15:0] stat_slot  [`EOPB_SLOT_CNT];
  logic [15:0] ctrl_slot  [`EOPB_SLOT_CNT];
  logic        apply_req;
  logic        bad_write;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `EOPB_OCTET_CNT; i++) begin
        octet[i] <= `EOPB_OCTET_RST;
      end
    end else if (reg_wr && reg_addr >= `EOPB_A_OCTET0 && reg_addr <= `EOPB_A_OCTET_LAST) begin
      octet[4'(reg_addr - `EOPB_A_OCTET0)] <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      speed_stage <= `EOPB_SPEED_AUTO;
      in_sel      <= 4'h0;
      out_sel     <= 4'h0;
    end else if (reg_wr) begin
      if (reg_addr == `EOPB_A_SPEED && reg_wdata <= 16'({14'h0, `EOPB_SPEED_MAX})) begin
        speed_stage <= reg_wdata[1:0];
      end
      if (reg_addr == `EOPB_A_IN_SEL && reg_wdata <= 16'({12'h0, `EOPB_SEL_MAX})) begin
        in_sel <= reg_wdata[3:0];
      end
      if (reg_addr == `EOPB_A_OUT_SEL && reg_wdata <= 16'({12'h0, `EOPB_SEL_MAX})) begin
        out_sel <= reg_wdata[3:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bad_write <= 1'b0;
    end else if (reg_wr) begin
      bad_write <= (reg_addr == `EOPB_A_SPEED && reg_wdata > 16'({14'h0, `EOPB_SPEED_MAX}))
        || ((reg_addr == `EOPB_A_IN_SEL || reg_addr == `EOPB_A_OUT_SEL)
            && reg_wdata > 16'({12'h0, `EOPB_SEL_MAX}));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `EOPB_SLOT_CNT; i++) begin
        stat_slot[i] <= `EOPB_SLOT_RST;
        ctrl_slot[i] <= `EOPB_SLOT_RST;
      end
    end else if (reg_wr) begin
      if (reg_addr >= `EOPB_A_STAT_SLOT0 && reg_addr <= `EOPB_A_STAT_SLOT7) begin
        stat_slot[3'(reg_addr - `EOPB_A_STAT_SLOT0)] <= reg_wdata;
      end
      if (reg_addr >= `EOPB_A_CTRL_SLOT0 && reg_addr <= `EOPB_A_CTRL_SLOT7) begin
        ctrl_slot[3'(reg_addr - `EOPB_A_CTRL_SLOT0)] <= reg_wdata;
      end
    end
  end

  assign apply_req = is_wr(reg_addr, `EOPB_A_APPLY) && reg_wdata == `EOPB_APPLY_VAL;

  // ----------------------------------------
  // Apply and restart
  // ----------------------------------------
  logic        started;
  logic [2:0]  warm_cnt;
  logic [3:0]  restart_cnt;
  logic [1:0]  speed_act;

  // Power-up latch stays open until the switch filter has settled
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      warm_cnt <= 3'h0;
    end else if (!started) begin
      warm_cnt <= 3'(warm_cnt + 3'h1);
    end
  end

  assign started = warm_cnt == `EOPB_WARM_CYC;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      proto_ind <= 1'b0;
    end else if (!started || apply_req) begin
      proto_ind <= sw_level;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ip_addr   <= 32'h0000_0000;
      net_mask  <= 32'h0000_0000;
      gateway   <= 32'h0000_0000;
      speed_act <= `EOPB_SPEED_AUTO;
      in_instance  <= 8'h00;
      out_instance <= 8'h00;
    end else if (apply_req) begin
      // Leftmost octet in the top byte, IPv4 only
      ip_addr   <= {octet[0], octet[1], octet[2], octet[3]};
      net_mask  <= {octet[4], octet[5], octet[6], octet[7]};
      gateway   <= {octet[8], octet[9], octet[10], octet[11]};
      speed_act <= speed_stage;
      in_instance  <= in_inst_of(in_sel);
      out_instance <= out_inst_of(out_sel);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stat_cnt <= `EOPB_SEL_LEGACY_CNT;
      ctrl_cnt <= `EOPB_SEL_LEGACY_CNT;
    end else if (apply_req) begin
      if (in_sel >= `EOPB_SEL_PARAM_MIN) begin
        stat_cnt <= cnt_of(in_sel);
      end
      if (out_sel >= `EOPB_SEL_PARAM_MIN) begin
        ctrl_cnt <= cnt_of(out_sel);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      restart_cnt <= 4'h0;
      nv_commit   <= 1'b0;
    end else begin
      nv_commit <= apply_req;
      if (apply_req) begin
        restart_cnt <= `EOPB_RESTART_CYC;
      end else if (restart_cnt != 4'h0) begin
        restart_cnt <= 4'(restart_cnt - 4'h1);
      end
    end
  end

  assign comm_restart = restart_cnt != 4'h0;

  eopb_speed_pick u_speed (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .speed_sel  (speed_act),
    .can_100    (c100_level),
    .can_10     (c10_level),
    .link_speed (link_speed)
  );

  // ----------------------------------------
  // Cyclic slot lookup
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stat_param_addr <= `EOPB_SLOT_RST;
      stat_idx_valid  <= 1'b0;
      ctrl_param_addr <= `EOPB_SLOT_RST;
      ctrl_idx_valid  <= 1'b0;
    end else begin
      stat_param_addr <= stat_slot[stat_idx];
      stat_idx_valid  <= {1'b0, stat_idx} < stat_cnt;
      ctrl_param_addr <= ctrl_slot[ctrl_idx];
      ctrl_idx_valid  <= {1'b0, ctrl_idx} < ctrl_cnt;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = 16'h0000;
    if (reg_addr >= `EOPB_A_OCTET0 && reg_addr <= `EOPB_A_OCTET_LAST) begin
      next_rdata = {8'h00, octet[4'(reg_addr - `EOPB_A_OCTET0)]};
    end else if (reg_addr >= `EOPB_A_STAT_SLOT0 && reg_addr <= `EOPB_A_STAT_SLOT7) begin
      next_rdata = stat_slot[3'(reg_addr - `EOPB_A_STAT_SLOT0)];
    end else if (reg_addr >= `EOPB_A_CTRL_SLOT0 && reg_addr <= `EOPB_A_CTRL_SLOT7) begin
      next_rdata = ctrl_slot[3'(reg_addr - `EOPB_A_CTRL_SLOT0)];
    end else begin
      case (reg_addr)
        `EOPB_A_VERSION:  next_rdata = VERSION_CODE;
        `EOPB_A_LED:      next_rdata = {12'h000, led_state};
        `EOPB_A_SPEED:    next_rdata = {14'h0000, speed_stage};
        // Selectors only visible in industrial-protocol mode
        `EOPB_A_IN_SEL:   next_rdata = proto_ind ? {12'h000, in_sel} : 16'h0000;
        `EOPB_A_OUT_SEL:  next_rdata = proto_ind ? {12'h000, out_sel} : 16'h0000;
        `EOPB_A_STAT_CNT: next_rdata = {12'h000, stat_cnt};
        `EOPB_A_CTRL_CNT: next_rdata = {12'h000, ctrl_cnt};
        `EOPB_A_APPLY:    next_rdata = 16'h0000;
        `EOPB_A_STATUS:   next_rdata = {12'h000, bad_write, comm_restart,
                                        link_speed == eopb_pkg::EOPB_LINK_100, proto_ind};
        default:          next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule : eopb_bank

// file: rtl/eopb_cfg.svh
/*
 Address map, field positions, reset values and ranges for the Ethernet
 option parameter bank. Included by the design modules, the checker and the testbench.
*/
`ifndef EOPB_CFG_SVH
`define EOPB_CFG_SVH

// ----------------------------------------
// Register offsets (word index)
// ----------------------------------------
`define EOPB_A_VERSION     6'h00
`define EOPB_A_LED         6'h01
`define EOPB_A_OCTET0      6'h02
`define EOPB_A_OCTET_LAST  6'h0d
`define EOPB_A_SPEED       6'h0e
`define EOPB_A_IN_SEL      6'h0f
`define EOPB_A_STAT_CNT    6'h10
`define EOPB_A_STAT_SLOT0  6'h11
`define EOPB_A_STAT_SLOT7  6'h18
`define EOPB_A_OUT_SEL     6'h19
`define EOPB_A_CTRL_CNT    6'h1a
`define EOPB_A_CTRL_SLOT0  6'h1b
`define EOPB_A_CTRL_SLOT7  6'h22
`define EOPB_A_APPLY       6'h23
`define EOPB_A_STATUS      6'h24

// ----------------------------------------
// Values and limits
// ----------------------------------------
`define EOPB_SPEED_AUTO    2'h0
`define EOPB_SPEED_100     2'h1
`define EOPB_SPEED_10      2'h2
`define EOPB_SPEED_MAX     2'h2
`define EOPB_SEL_MAX       4'hb
`define EOPB_SEL_PARAM_MIN 4'h4
`define EOPB_SEL_LEGACY_CNT 4'h0
`define EOPB_OCTET_RST     8'h00
`define EOPB_SLOT_RST      16'h0000
`define EOPB_APPLY_VAL     16'h0001
`define EOPB_RESTART_CYC   4'h8
`define EOPB_WARM_CYC      3'h5
`define EOPB_SLOT_CNT      8
`define EOPB_OCTET_CNT     12

`endif

// file: rtl/eopb_pkg.sv
/*
 Types shared by the parameter bank modules.
 Assumes eopb_cfg.svh is on the include path.
*/
package eopb_pkg;
  typedef enum logic [1:0] {
    EOPB_LINK_DOWN,
    EOPB_LINK_100,
    EOPB_LINK_10
  } eopb_speed_t;

  typedef struct packed {
    logic [5:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } eopb_req_t;

  typedef struct packed {
    logic        proto_ind;
    logic [3:0]  in_sel;
    logic [3:0]  out_sel;
    logic [3:0]  stat_cnt;
    logic [3:0]  ctrl_cnt;
    logic [1:0]  speed;
  } eopb_active_t;
endpackage : eopb_pkg

// file: rtl/eopb_speed_pick.sv
/*
 Link speed resolution: forced or auto, auto takes the fastest offered.
 Assumes link ability inputs are already synchronised to ref_clk.
*/
`timescale 1ns/1ns
`include "eopb_cfg.svh"

module eopb_speed_pick (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // Selection and network ability
  input  wire logic [1:0]           speed_sel,
  input  wire logic                 can_100,
  input  wire logic                 can_10,
  // Result
  output eopb_pkg::eopb_speed_t     link_speed
);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      link_speed <= eopb_pkg::EOPB_LINK_DOWN;
    end else begin
      case (speed_sel)
        `EOPB_SPEED_AUTO: begin
          if (can_100) begin
            link_speed <= eopb_pkg::EOPB_LINK_100;
          end else if (can_10) begin
            link_speed <= eopb_pkg::EOPB_LINK_10;
          end else begin
            link_speed <= eopb_pkg::EOPB_LINK_DOWN;
          end
        end
        `EOPB_SPEED_100: begin
          link_speed <= can_100 ? eopb_pkg::EOPB_LINK_100 : eopb_pkg::EOPB_LINK_DOWN;
        end
        `EOPB_SPEED_10: begin
          link_speed <= can_10 ? eopb_pkg::EOPB_LINK_10 : eopb_pkg::EOPB_LINK_DOWN;
        end
        default: begin
          link_speed <= eopb_pkg::EOPB_LINK_DOWN;
        end
      endcase
    end
  end
endmodule : eopb_speed_pick

// file: verification/eopb_bank_checker.sv
/*
 Port checks of the parameter bank, bound into each bank instance.
 Assumes one clock ref_clk and a synchronous active-low rst_n.
*/
`timescale 1ns/1ns
`include "eopb_cfg.svh"

module eopb_bank_checker #(
  parameter logic [15:0] VERSION_CODE = 16'h0001 // Arbitrary value
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Register port
  input wire logic [5:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Active configuration
  input wire logic [3:0]  led_state,
  input wire logic [31:0] ip_addr,
  input wire logic [31:0] net_mask,
  input wire logic [31:0] gateway,
  input wire logic [7:0]  in_instance,
  input wire logic [7:0]  out_instance,
  input wire logic [3:0]  stat_cnt,
  input wire logic [3:0]  ctrl_cnt,
  input wire logic        comm_restart,
  input wire logic        nv_commit,
  // Slot lookup
  input wire logic [2:0]  stat_idx,
  input wire logic        stat_idx_valid,
  input wire logic [2:0]  ctrl_idx,
  input wire logic        ctrl_idx_valid
);
  logic apply_wr;
  assign apply_wr = reg_wr && reg_addr == `EOPB_A_APPLY && reg_wdata == `EOPB_APPLY_VAL;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  AST_VERSION: assert property (reg_rd && reg_addr == `EOPB_A_VERSION |=>
    reg_rdata == VERSION_CODE) else $error("version read wrong");
  AST_LED: assert property (reg_rd && reg_addr == `EOPB_A_LED |=>
    reg_rdata == {12'h000, $past(led_state)}) else $error("indicator mirror wrong");
  AST_STAGED: assert property ($changed({ip_addr, net_mask, gateway, in_instance,
    out_instance, stat_cnt, ctrl_cnt}) |-> $past(apply_wr)) else $error("active set moved");
  AST_NV_SET: assert property (apply_wr |=> nv_commit)
    else $error("commit pulse missing");
  AST_NV_CAUSE: assert property (nv_commit |-> $past(apply_wr))
    else $error("commit pulse without apply");
  AST_RESTART: assert property (apply_wr |=> comm_restart [*8])
    else $error("restart too short");
  AST_RESTART_END: assert property (apply_wr ##1 !apply_wr [*8] |=> !comm_restart)
    else $error("restart too long");
  AST_STAT_VALID: assert property (stat_idx_valid == ($past(stat_idx) < $past(stat_cnt)))
    else $error("status slot valid wrong");
  AST_CTRL_VALID: assert property (ctrl_idx_valid == ($past(ctrl_idx) < $past(ctrl_cnt)))
    else $error("control slot valid wrong");

  COV_APPLY: cover property (apply_wr ##1 nv_commit);
  COV_PART: cover property ($fell(stat_idx_valid));
  COV_VER: cover property (reg_rd && reg_addr == `EOPB_A_VERSION);
endmodule : eopb_bank_checker

bind eopb_bank eopb_bank_checker #(.VERSION_CODE(VERSION_CODE)) eopb_bank_checker_i (
  .ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .led_state,
  .ip_addr, .net_mask, .gateway, .in_instance, .out_instance, .stat_cnt, .ctrl_cnt,
  .comm_restart, .nv_commit, .stat_idx, .stat_idx_valid, .ctrl_idx, .ctrl_idx_valid);

// file: verification/eopb_net_model.sv
/*
 Far side: network speed offer, indicator sources, client slot scan.
 Assumes the bench sets the offer and the indicator pattern.
*/
`timescale 1ns/1ns

module eopb_net_model (
  // Clock and bench controls
  input  wire logic       ref_clk,
  input  wire logic [1:0] offer,
  input  wire logic [3:0] led_pat,
  // Toward the bank
  output logic            net_can_100,
  output logic            net_can_10,
  output logic [3:0]      led_state = 4'h0,
  output logic [2:0]      stat_idx = 3'h0,
  output logic [2:0]      ctrl_idx = 3'h0
);
  assign net_can_100 = offer[1];
  assign net_can_10  = offer[0];
  // Scan runs past the count too
  always @(posedge ref_clk) begin
    stat_idx  <= stat_idx + 3'h1;
    ctrl_idx  <= ctrl_idx + 3'h3;
    led_state <= led_pat;
  end
endmodule : eopb_net_model

// file: verification/testbench.sv
/*
 Self-checking bench of the parameter bank over its strobe port.
 Assumes the bank, its bound checker and the far-side model.
*/
`timescale 1ns/1ns
`include "eopb_cfg.svh"

module testbench;
  localparam logic [15:0] VER = 16'h5a3c; // Arbitrary value
  logic                  ref_clk, rst_n, reg_wr, reg_rd, proto_switch, proto_ind;
  logic                  net_can_100, net_can_10, comm_restart, nv_commit;
  logic                  stat_idx_valid, ctrl_idx_valid;
  logic [5:0]            reg_addr;
  logic [15:0]           reg_wdata, reg_rdata, stat_param_addr, ctrl_param_addr, v;
  logic [31:0]           ip_addr, net_mask, gateway;
  logic [7:0]            in_instance, out_instance;
  logic [3:0]            stat_cnt, ctrl_cnt, led_state, led_pat, s, pc;
  logic [2:0]            stat_idx, ctrl_idx, k, j;
  logic [1:0]            offer;
  eopb_pkg::eopb_speed_t link_speed;
  logic [7:0]            oct [12];
  logic [7:0]            in_l [4];
  logic [7:0]            out_l [4];
  logic [5:0]            sp [6];
  int                    n_mismatch = 0;
  int                    comparisons = 0;
  int                    cyc = 0;

  eopb_bank #(.VERSION_CODE(VER)) eopb_bank_i (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .proto_switch, .net_can_100, .net_can_10, .led_state,
    .proto_ind, .ip_addr, .net_mask, .gateway, .in_instance, .out_instance, .stat_cnt,
    .ctrl_cnt, .link_speed, .comm_restart, .nv_commit, .stat_idx, .stat_param_addr,
    .stat_idx_valid, .ctrl_idx, .ctrl_param_addr, .ctrl_idx_valid);
  eopb_net_model eopb_net_model_i (.ref_clk, .offer, .led_pat, .net_can_100, .net_can_10,
    .led_state, .stat_idx, .ctrl_idx);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons = comparisons + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask : rd
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask : idle
  task automatic apply();
    wr(`EOPB_A_APPLY, `EOPB_APPLY_VAL);
    idle(12);
  endtask : apply
  task automatic stop_test();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    proto_switch = 1'b1;
    offer = 2'b11;
    led_pat = 4'ha;
    pc = 4'h0;
    oct = '{8'hc4, 8'ha8, 8'h0a, 8'h83, 8'hff, 8'hff, 8'hff, 8'h00, 8'hc4, 8'ha8, 8'h0a, 8'h01};
    in_l = '{8'h46, 8'h47, 8'h6e, 8'h6f};
    out_l = '{8'h14, 8'h15, 8'h64, 8'h65};
    // Rows: select, offer, expected speed
    sp = '{6'h0d, 6'h06, 6'h1d, 6'h2e, 6'h14, 6'h28};
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    idle(8);
    chk(proto_ind, 1);
    apply();
    chk(proto_ind, 1);
    wr(`EOPB_A_VERSION, 16'hffff);
    rd(`EOPB_A_VERSION, v);
    chk(v, VER);
    rd(6'h3f, v);
    chk(v, 0);
    for (int i = 0; i < 2; i++) begin
      led_pat <= i ? 4'h5 : 4'ha;
      idle(2);
      rd(`EOPB_A_LED, v);
      chk(v, i ? 16'h0005 : 16'h000a);
    end
    for (int i = 0; i < 12; i++) wr(6'(`EOPB_A_OCTET0 + i), {8'h00, oct[i]});
    wr(`EOPB_A_APPLY, 16'h0002);
    idle(2);
    chk(ip_addr, 0);
    rd(6'(`EOPB_A_OCTET0 + 3), v);
    chk(v, 16'h0083);
    apply();
    chk(ip_addr, 32'hc4a8_0a83);
    chk(net_mask, 32'hffff_ff00);
    chk(gateway, 32'hc4a8_0a01);
    for (int i = 0; i < 6; i++) begin
      offer <= sp[i][3:2];
      wr(`EOPB_A_SPEED, {14'h0000, sp[i][5:4]});
      idle(8);
      apply();
      chk(32'(link_speed), sp[i][1:0]);
    end
    wr(`EOPB_A_SPEED, 16'h0003);
    rd(`EOPB_A_SPEED, v);
    chk(v, 16'h0002);
    rd(`EOPB_A_STATUS, v);
    chk(v[3], 1);
    for (int i = 0; i < 12; i++) begin
      s = 4'((i + 4) % 12);
      wr(`EOPB_A_IN_SEL, {12'h000, s});
      wr(`EOPB_A_OUT_SEL, {12'h000, s});
      idle(2);
      chk(stat_cnt, pc);
      apply();
      if (s >= 4'h4) pc = s - 4'h3;
      chk(in_instance, s < 4'h4 ? in_l[s[1:0]] : 8'd141 + s - 8'd4);
      chk(out_instance, s < 4'h4 ? out_l[s[1:0]] : 8'd121 + s - 8'd4);
      chk(stat_cnt, pc);
      chk(ctrl_cnt, pc);
    end
    wr(`EOPB_A_IN_SEL, 16'h000c);
    rd(`EOPB_A_IN_SEL, v);
    chk(v, 16'h0003);
    for (int i = 0; i < 8; i++) begin
      wr(6'(`EOPB_A_STAT_SLOT0 + i), 16'ha000 + 16'(i));
      wr(6'(`EOPB_A_CTRL_SLOT0 + i), 16'hb000 + 16'(i));
    end
    apply();
    for (int i = 0; i < 8; i++) begin
      k = stat_idx;
      j = ctrl_idx;
      @(posedge ref_clk);
      chk(stat_param_addr, 16'ha000 + k);
      chk(ctrl_param_addr, 16'hb000 + j);
    end
    wr(`EOPB_A_IN_SEL, 16'h0005);
    wr(`EOPB_A_OUT_SEL, 16'h0005);
    apply();
    proto_switch <= 1'b0;
    idle(10);
    chk(proto_ind, 1);
    apply();
    chk(proto_ind, 0);
    rd(`EOPB_A_IN_SEL, v);
    chk(v, 0);
    rd(`EOPB_A_OUT_SEL, v);
    chk(v, 0);
    stop_test();
  end
endmodule : testbench
